// ==== hw/ebp_pwm.sv ====
`timescale 1ns/1ps
module ebp_pwm
  import ebp_pkg::*;
#(
  parameter bit HALF_ONLY = 1'b0
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Shutdown sources, asynchronous
  input  wire logic       ext_int_pin_n,
  input  wire logic [1:0] comparator_output,
  // Bridge outputs
  output logic            pwm_out_a,
  output logic            pwm_oe_a,
  output logic            pwm_out_b,
  output logic            pwm_oe_b,
  output logic            pwm_out_c,
  output logic            pwm_oe_c,
  output logic            pwm_out_d,
  output logic            pwm_oe_d
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] mc;
    logic [7:0] duty;
    logic [7:0] per;
    logic [7:0] dbr;
    logic [2:0] sd_sel;
    logic [1:0] lvl_ac;
    logic [1:0] lvl_bd;
    logic       flag;
    logic [1:0] pre_sel;
    logic [3:0] pre;
    logic [1:0] fine;
    logic [7:0] tmr;
    logic [9:0] duty_act;
    logic       dir_act;
    logic [2:0] sync1;
    logic [2:0] sync2;
    ebp_phase_t phase;
    logic [7:0] rdata;
    logic [3:0] pin;
    logic [3:0] oe;
  } ebp_st_t;

  ebp_st_t q;
  ebp_st_t d;

  logic [1:0] cfg;
  logic [4:0] plen;
  logic       tick;
  logic       last_step;
  logic [9:0] tb;
  logic       raw;
  logic [2:0] src;
  logic       cond;
  logic       wr_sd;
  logic       en_fn;
  logic       shut;
  logic       full;
  logic       dir_new;
  logic       dir_pend;
  logic       blank;
  logic       swap;
  logic       dir_use;
  logic       mod;
  logic [3:0] act;
  logic [3:0] used;
  logic [3:0] pol;
  logic [3:0] sd_pin;
  logic [3:0] sd_oe;

  ebp_db_if dbi ();

  // ****************************************
  // Time base
  // ****************************************

  // Mode and prescale decode
  assign cfg  = q.mc[MC_CFG_POS +: 2];
  assign plen = prescale_len(q.pre_sel);
  assign en_fn = (q.mc[MC_FN_POS +: 2] == FN_PWM);

  // One fine step per prescale length of clocks
  assign tick      = (q.pre == 4'(plen - 5'h01));
  assign last_step = tick && (q.fine == 2'h3) && (q.tmr == q.per);

  // Ten-bit count: timer above, fine phase below
  assign tb  = {q.tmr, q.fine};
  assign raw = (tb < q.duty_act);

  // ****************************************
  // Shutdown sources
  // ****************************************

  // Pin is active low; comparators active high
  assign src   = {q.sync2[2:1], ~q.sync2[0]};
  assign cond  = |(q.sd_sel & src);
  assign wr_sd = reg_wr && (reg_addr == ADDR_SDC);
  assign shut  = q.flag || cond;

  // ****************************************
  // Full-bridge direction
  // ****************************************
  assign full     = cfg[0];
  assign dir_new  = cfg[1];
  assign dir_pend = full && (dir_new != q.dir_act);

  // Blank the modulated leg for the last four fine steps
  assign blank = dir_pend && (q.tmr == q.per);

  // Unmodulated legs swap one fine step before period end
  assign swap    = blank && (q.fine == 2'h3);
  assign dir_use = swap ? dir_new : q.dir_act;
  assign mod     = raw && !blank;

  // ****************************************
  // Output shaping
  // ****************************************

  // Dead-band unit sees the raw waveform
  assign dbi.raw  = raw;
  assign dbi.dead = q.dbr[6:0];

  ebp_deadband u_db (
    .clk  (clk),
    .srst (srst),
    .dbi  (dbi.db)
  );

  // Active levels per pin, order d c b a
  assign act = (cfg == CFG_SINGLE) ? {3'b000, raw} :
               (cfg == CFG_HALF)   ? {2'b00, dbi.out_b, dbi.out_a} :
               dir_use             ? {2'b01, mod, 1'b0} :
                                     {mod, 2'b00, 1'b1};

  // Pins in use for the mode
  assign used = (cfg == CFG_SINGLE) ? 4'h1 :
                (cfg == CFG_HALF)   ? 4'h3 :
                {~HALF_ONLY, ~HALF_ONLY, 2'b11};

  // Pair polarity, 1 means active low
  assign pol = {q.mc[FN_POL_BD], q.mc[FN_POL_AC],
                q.mc[FN_POL_BD], q.mc[FN_POL_AC]};

  // Shutdown levels per pair
  assign sd_pin = {q.lvl_bd == SDL_HIGH, q.lvl_ac == SDL_HIGH,
                   q.lvl_bd == SDL_HIGH, q.lvl_ac == SDL_HIGH};
  assign sd_oe  = {~q.lvl_bd[1], ~q.lvl_ac[1],
                   ~q.lvl_bd[1], ~q.lvl_ac[1]};

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;

    // Two-stage synchronisers for the shutdown pins
    d.sync1 = {comparator_output, ext_int_pin_n};
    d.sync2 = q.sync1;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_MODE: d.mc   = reg_wdata;
        ADDR_DUTY: d.duty = reg_wdata;
        ADDR_PER:  d.per  = reg_wdata;
        ADDR_DBR:  d.dbr  = reg_wdata;
        ADDR_SDC:
        begin
          d.sd_sel = reg_wdata[SD_SEL_POS +: 3];
          d.lvl_ac = reg_wdata[SD_AC_POS +: 2];
          d.lvl_bd = reg_wdata[SD_BD_POS +: 2];
        end
        ADDR_TCFG: d.pre_sel = reg_wdata[TC_PRE_POS +: 2];
        default: ;
      endcase
    end

    // Prescaler, fine phase and timer
    d.pre = tick ? 4'h0 : q.pre + 4'h1;
    if (tick)
    begin
      d.fine = q.fine + 2'h1;
      if (q.fine == 2'h3)
      begin
        d.tmr = (q.tmr == q.per) ? 8'h00 : q.tmr + 8'h01;
      end
    end

    // Duty and direction take effect at the period boundary
    if (last_step)
    begin
      d.duty_act = {q.duty, q.mc[MC_DLO_POS +: 2]};
      d.dir_act  = dir_new;
    end

    // Shutdown flag: a live condition beats any write
    if (cond)
    begin
      d.flag = 1'b1;
    end
    else if (wr_sd)
    begin
      d.flag = reg_wdata[SD_FLAG];
    end
    else if (q.flag && q.dbr[DBR_RSEN])
    begin
      d.flag = 1'b0;
    end

    // Run phase
    case (q.phase)
      ST_OFF:
      begin
        if (en_fn)
        begin
          d.phase = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (!en_fn)
        begin
          d.phase = ST_OFF;
        end
        else if (last_step && !shut)
        begin
          d.phase = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!en_fn)
        begin
          d.phase = ST_OFF;
        end
        else if (shut)
        begin
          d.phase = ST_WAIT;
        end
      end
      default: d.phase = ST_OFF;
    endcase

    // Read data, valid only in the cycle after the strobe
    d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_MODE: d.rdata = q.mc;
        ADDR_DUTY: d.rdata = q.duty;
        ADDR_PER:  d.rdata = q.per;
        ADDR_DBR:  d.rdata = q.dbr;
        ADDR_SDC:  d.rdata = {q.flag, q.sd_sel, q.lvl_ac, q.lvl_bd};
        ADDR_TCFG: d.rdata = {6'h00, q.pre_sel};
        ADDR_CNT:  d.rdata = q.tmr;
        default:   d.rdata = 8'h00;
      endcase
    end

    // Pin drive
    if (q.phase == ST_OFF)
    begin
      d.pin = 4'h0;
      d.oe  = 4'h0;
    end
    else if (shut)
    begin
      d.pin = sd_pin & sd_oe & used;
      d.oe  = sd_oe & used;
    end
    else if (q.phase == ST_RUN)
    begin
      d.pin = (act ^ pol) & used;
      d.oe  = used;
    end
    else
    begin
      d.pin = pol & used;
      d.oe  = used;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q       <= '0;
      q.phase <= ST_OFF;
      q.sync1 <= SYNC_RST;
      q.sync2 <= SYNC_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign pwm_out_a = q.pin[0];
  assign pwm_oe_a  = q.oe[0];
  assign pwm_out_b = q.pin[1];
  assign pwm_oe_b  = q.oe[1];
  assign pwm_out_c = q.pin[2];
  assign pwm_oe_c  = q.oe[2];
  assign pwm_out_d = q.pin[3];
  assign pwm_oe_d  = q.oe[3];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Period measurement helper
  logic [14:0] cyc_q;
  logic        quiet_q;
  logic [14:0] per_len;

  assign per_len = 15'(plen) * 15'h0004 * (15'(q.per) + 15'h0001);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cyc_q   <= 15'h0000;
      quiet_q <= 1'b0;
    end
    else
    begin
      cyc_q   <= last_step ? 15'h0000 : cyc_q + 15'h0001;
      quiet_q <= last_step ? 1'b1 :
                 (reg_wr && (reg_addr == ADDR_PER || reg_addr == ADDR_TCFG)) ? 1'b0 : quiet_q;
    end
  end

  sequence s_dir_blank;
    q.phase == ST_RUN && !shut && dir_pend && q.tmr == q.per;
  endsequence

  sequence s_dir_swap;
    q.phase == ST_RUN && !shut && swap && last_step;
  endsequence

  period_len_a:
  assert property (last_step && quiet_q && !(reg_wr && reg_addr == ADDR_PER) |->
                   cyc_q == per_len - 15'h0001)
  else $error("period length wrong");

  flag_set_a:
  assert property (cond |=> q.flag)
  else $error("shutdown condition did not set flag");

  fw_clear_block_a:
  assert property (cond && wr_sd && !reg_wdata[SD_FLAG] |=> q.flag)
  else $error("flag cleared while condition present");

  auto_clear_a:
  assert property (q.flag && !cond && q.dbr[DBR_RSEN] &&
                   !(wr_sd && reg_wdata[SD_FLAG]) |=> !q.flag)
  else $error("auto-restart did not clear flag");

  shut_hold_a:
  assert property (cond && q.phase != ST_OFF |=> q.phase != ST_RUN [*2])
  else $error("outputs ran during shutdown");

  shut_low_a:
  assert property (q.flag && q.phase != ST_OFF && q.lvl_ac == SDL_LOW |=>
                   !pwm_out_a && pwm_oe_a)
  else $error("pair A/C not driven low in shutdown");

  shut_hiz_a:
  assert property (q.flag && q.lvl_bd[1] |=> !pwm_oe_b && !pwm_oe_d)
  else $error("pair B/D not released in shutdown");

  restart_wait_a:
  assert property ($fell(q.flag) && q.phase == ST_WAIT && !last_step |=>
                   q.phase == ST_WAIT)
  else $error("output resumed before period start");

  fwd_drive_a:
  assert property (q.phase == ST_RUN && cfg == CFG_FWD && !dir_pend |->
                   act[0] && !act[1] && !act[2] && act[3] == raw)
  else $error("forward drive pattern wrong");

  rev_drive_a:
  assert property (q.phase == ST_RUN && cfg == CFG_REV && !dir_pend |->
                   act[2] && !act[0] && !act[3] && act[1] == raw)
  else $error("reverse drive pattern wrong");

  half_excl_a:
  assert property (cfg == CFG_HALF |-> !(act[0] && act[1]) && act[3:2] == 2'b00)
  else $error("half-bridge outputs overlap");

  dir_blank_a:
  assert property (s_dir_blank |-> !act[1] && !act[3])
  else $error("modulated outputs not blanked");

  dir_swap_a:
  assert property (s_dir_swap |=> q.dir_act == dir_new ##0 q.phase == ST_RUN)
  else $error("unmodulated outputs did not swap");

  enable_off_a:
  assert property (!en_fn ##1 !en_fn |=> q.oe == 4'h0)
  else $error("pins driven with enhanced PWM disabled");

endmodule : ebp_pwm

// ==== common/ebp_pkg.sv ====
package ebp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS      = 8;
  localparam int TOSC_NS     = 8;
  localparam int TCY_NS      = 4 * TOSC_NS;
  localparam int DB_STEP_CYC = (TCY_NS / CLK_NS < 1) ? 1 : TCY_NS / CLK_NS;

  // ****************************************
  // Register indices and field positions
  // ****************************************
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_DUTY = 3'h1;
  localparam logic [2:0] ADDR_PER  = 3'h2;
  localparam logic [2:0] ADDR_DBR  = 3'h3;
  localparam logic [2:0] ADDR_SDC  = 3'h4;
  localparam logic [2:0] ADDR_TCFG = 3'h5;
  localparam logic [2:0] ADDR_CNT  = 3'h6;
  localparam int MC_FN_POS  = 2;
  localparam int MC_DLO_POS = 4;
  localparam int MC_CFG_POS = 6;
  localparam int FN_POL_BD  = 0;
  localparam int FN_POL_AC  = 1;
  localparam int DBR_RSEN   = 7;
  localparam int SD_FLAG    = 7;
  localparam int SD_SEL_POS = 4;
  localparam int SD_AC_POS  = 2;
  localparam int SD_BD_POS  = 0;
  localparam int TC_PRE_POS = 0;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD    = 2'h1;
  localparam logic [1:0] CFG_HALF   = 2'h2;
  localparam logic [1:0] CFG_REV    = 2'h3;
  localparam logic [1:0] FN_PWM     = 2'h3;
  localparam logic [1:0] SDL_LOW    = 2'h0;
  localparam logic [1:0] SDL_HIGH   = 2'h1;
  localparam logic [4:0] PRE_1      = 5'h01;
  localparam logic [4:0] PRE_4      = 5'h04;
  localparam logic [4:0] PRE_16     = 5'h10;
  localparam logic [2:0] SYNC_RST   = 3'h1;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } ebp_phase_t;

  // Prescale factor from its select code
  function automatic logic [4:0] prescale_len(input logic [1:0] sel);
    case (sel)
      2'h0:    prescale_len = PRE_1;
      2'h1:    prescale_len = PRE_4;
      default: prescale_len = PRE_16;
    endcase
  endfunction : prescale_len

endpackage : ebp_pkg

// ==== common/ebp_db_if.sv ====
`timescale 1ns/1ps
// Raw waveform and delay count out, delayed half-bridge pair back
interface ebp_db_if;
  logic       raw;
  logic [6:0] dead;
  logic       out_a;
  logic       out_b;
  modport core (output raw, output dead, input out_a, input out_b);
  modport db (input raw, input dead, output out_a, output out_b);
endinterface : ebp_db_if

// ==== hw/ebp_deadband.sv ====
`timescale 1ns/1ps
module ebp_deadband
  import ebp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Waveform in, delayed pair out
  ebp_db_if.db     dbi
);

  typedef struct packed {
    logic       raw;
    logic [8:0] cnt;
  } ebp_db_st_t;

  ebp_db_st_t q;
  ebp_db_st_t d;
  logic [8:0] need;
  logic       on;

  // Delay in clocks: instruction cycles times count
  assign need = 9'(dbi.dead) * 9'(DB_STEP_CYC);

  // Edge holds both outputs off until the count is reached
  assign on = (need == 9'h000) || ((dbi.raw == q.raw) && (q.cnt >= need));

  // Count clocks since the last edge, saturating
  always_comb
  begin
    d     = q;
    d.raw = dbi.raw;
    if (dbi.raw != q.raw)
    begin
      d.cnt = 9'h001;
    end
    else if (q.cnt != 9'h1ff)
    begin
      d.cnt = q.cnt + 9'h001;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Waveform on A, complement on B, both delayed
  assign dbi.out_a = dbi.raw && on;
  assign dbi.out_b = !dbi.raw && on;

  // ****************************************
  // Checks
  // ****************************************
  db_rise_hold_a:
  assert property (@(posedge clk) disable iff (srst)
    $rose(dbi.raw) && dbi.dead == 7'h01 |->
      (!dbi.out_a) [*4] ##1 (dbi.out_a || !dbi.raw || dbi.dead != 7'h01))
  else $error("dead-band delay of one count not honoured");

endmodule : ebp_deadband

// ==== dv/ebp_bridge_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Power bridge gate inputs and fault sensors
// ****************************************
module ebp_bridge_model (
  // Pin drive from the device
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // Fault requests from the bench
  input  wire logic [2:0] fault_req,
  // Gate levels seen by the switches
  output logic      [3:0] gate,
  // Shutdown sources back to the device
  output logic            trip_pin_n,
  output logic      [1:0] trip_cmp
);
  // Gate inputs carry pull-downs, so a released pin reads low
  assign gate = pin_out & pin_oe;
  // Fault line 0 pulls the trip pin low, lines 1 and 2 trip the comparators
  assign trip_pin_n = ~fault_req[0];
  assign trip_cmp   = fault_req[2:1];
endmodule : ebp_bridge_model

// ==== dv/tb_ebp_pwm.sv ====
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_ebp_pwm
  import ebp_pkg::*;
();
  // ****************************************
  // Signals
  // ****************************************
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        ext_int_pin_n;
  logic [1:0]  comparator_output;
  logic [2:0]  fault_req = 3'h0;
  logic [3:0]  pin_out, pin_oe, gate, oe_h;
  logic [15:0] exp_q[$];
  logic [15:0] m_val = 16'h0000;
  logic [15:0] e_v;
  logic        m_vld = 1'b0;
  logic        rd_d = 1'b0;
  int          cnt[5];
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;

  // Clock at 125 MHz
  always #4 clk = ~clk;

  // ****************************************
  // Device, half-only variant and bridge
  // ****************************************
  ebp_pwm #(.HALF_ONLY(1'b0)) i_ebp_pwm (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_int_pin_n(ext_int_pin_n), .comparator_output(comparator_output),
    .pwm_out_a(pin_out[0]), .pwm_oe_a(pin_oe[0]), .pwm_out_b(pin_out[1]), .pwm_oe_b(pin_oe[1]),
    .pwm_out_c(pin_out[2]), .pwm_oe_c(pin_oe[2]), .pwm_out_d(pin_out[3]), .pwm_oe_d(pin_oe[3]));
  ebp_pwm #(.HALF_ONLY(1'b1)) i_ebp_pwm_h (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .ext_int_pin_n(ext_int_pin_n), .comparator_output(comparator_output),
    .pwm_out_a(), .pwm_oe_a(oe_h[0]), .pwm_out_b(), .pwm_oe_b(oe_h[1]),
    .pwm_out_c(), .pwm_oe_c(oe_h[2]), .pwm_out_d(), .pwm_oe_d(oe_h[3]));
  ebp_bridge_model i_ebp_bridge_model (.pin_out(pin_out), .pin_oe(pin_oe), .fault_req(fault_req),
    .gate(gate), .trip_pin_n(ext_int_pin_n), .trip_cmp(comparator_output));

  // ****************************************
  // Scoreboard and watchdog
  // ****************************************
  // Oldest note is compared against each read or measurement result
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
    begin
      e_v = exp_q.pop_front();
      `CHK({8'h00, reg_rdata}, e_v)
    end
    if (m_vld)
    begin
      e_v = exp_q.pop_front();
      `CHK(m_val, e_v)
    end
  end

  // Cuts a hang short well beyond the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      results();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({8'h00, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Hands a measured value to the scoreboard
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    m_val <= g;
    m_vld <= 1'b1;
    @(posedge clk);
    m_vld <= 1'b0;
  endtask : chk

  // Counts active cycles per gate, and any C/D drive of the half-only variant
  task automatic meas(input int n);
    cnt = '{default: 0};
    repeat (n)
    begin
      @(posedge clk);
      for (int i = 0; i < 4; i++)
        cnt[i] += (gate[i] === 1'b1);
      cnt[4] += (oe_h[3:2] !== 2'b00);
    end
  endtask : meas

  // Programs one mode and checks active time of every pin over four periods
  task automatic pwm_case(input logic [1:0] cfg, input logic [1:0] pol, input logic [1:0] pre,
                          input logic [6:0] db, input int d10);
    int         pf;
    int         t;
    int         w;
    int         e;
    int         act[4];
    logic [3:0] used;
    pf   = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16;
    t    = 16 * pf;
    w    = d10 * pf;
    used = (cfg == CFG_SINGLE) ? 4'h1 : (cfg == CFG_HALF) ? 4'h3 : 4'hf;
    act  = '{w, 0, 0, 0};
    if (cfg == CFG_HALF)
      act = '{(w > 4 * db) ? w - 4 * db : 0, (t - w > 4 * db) ? t - w - 4 * db : 0, 0, 0};
    else if (cfg == CFG_FWD)
      act = '{t, 0, 0, w};
    else if (cfg == CFG_REV)
      act = '{0, w, t, 0};
    wr(ADDR_TCFG, {6'h00, pre});
    wr(ADDR_PER, 8'h03);
    wr(ADDR_DBR, {1'b0, db});
    wr(ADDR_DUTY, 8'(d10 >> 2));
    wr(ADDR_MODE, {cfg, 2'(d10), FN_PWM, pol});
    repeat (2 * t + 264) @(posedge clk);
    meas(4 * t);
    for (int i = 0; i < 4; i++)
    begin
      e = !used[i] ? 0 : pol[(i % 2 == 0) ? FN_POL_AC : FN_POL_BD] ? 4 * (t - act[i]) : 4 * act[i];
      chk(16'(cnt[i]), 16'(e));
    end
    chk(16'(cnt[4]), 16'h0000);
  endtask : pwm_case

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'hc69a));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // Reset values of all indices, including the unmapped one
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    wr(ADDR_PER, 8'h5a);
    rd(ADDR_PER, 8'h5a);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
    // Every mode, polarity and prescale code with a random duty
    for (int k = 0; k < 4; k++)
      pwm_case(2'(k), 2'(k), 2'(k), 7'h03, $urandom_range(15, 1));
    pwm_case(CFG_HALF, 2'b00, 2'h0, 7'h01, 8);
    pwm_case(CFG_HALF, 2'b00, 2'h0, 7'h7f, 8);
    // Function select other than PWM leaves every pin released
    wr(ADDR_MODE, {CFG_FWD, 2'b00, 2'b10, 2'b00});
    repeat (40) @(posedge clk);
    chk({12'h000, pin_oe}, 16'h0000);
    // Comparator shutdown: A/C driven high, B/D released
    pwm_case(CFG_HALF, 2'b00, 2'h0, 7'h00, 8);
    wr(ADDR_SDC, 8'h26);
    fault_req <= 3'b010;
    repeat (4) @(posedge clk);
    chk({12'h000, pin_oe[1], pin_out[1], pin_oe[0], pin_out[0]}, 16'h0003);
    rd(ADDR_SDC, 8'ha6);
    wr(ADDR_SDC, 8'h26);
    rd(ADDR_SDC, 8'ha6);
    meas(32);
    chk(16'(cnt[0] + 64 * cnt[1]), 16'h0020);
    fault_req <= 3'b000;
    repeat (6) @(posedge clk);
    rd(ADDR_SDC, 8'ha6);
    wr(ADDR_SDC, 8'h26);
    rd(ADDR_SDC, 8'h26);
    pwm_case(CFG_HALF, 2'b00, 2'h0, 7'h00, 8);
    // Firmware shutdown with both pairs driven low
    wr(ADDR_SDC, 8'h80);
    repeat (4) @(posedge clk);
    chk({12'h000, pin_oe[1], pin_out[1], pin_oe[0], pin_out[0]}, 16'h000a);
    rd(ADDR_SDC, 8'h80);
    wr(ADDR_SDC, 8'h00);
    rd(ADDR_SDC, 8'h00);
    // An unselected source has no effect
    wr(ADDR_SDC, 8'h10);
    fault_req <= 3'b100;
    pwm_case(CFG_FWD, 2'b00, 2'h0, 7'h00, 5);
    fault_req <= 3'b000;
    // Auto-restart on the pin source
    wr(ADDR_DBR, 8'h80);
    rd(ADDR_DBR, 8'h80);
    fault_req <= 3'b001;
    repeat (6) @(posedge clk);
    rd(ADDR_SDC, 8'h90);
    fault_req <= 3'b000;
    repeat (6) @(posedge clk);
    rd(ADDR_SDC, 8'h10);
    pwm_case(CFG_REV, 2'b00, 2'h1, 7'h00, $urandom_range(15, 1));
    // Direction flip while running: blanking and swap sequence, then the new drive pattern
    pwm_case(CFG_FWD, 2'b01, 2'h1, 7'h00, $urandom_range(15, 1));
    repeat (4) @(posedge clk);
    results();
  end
endmodule : tb_ebp_pwm
